// ---- bench/tb_top.sv ----
// Self-checking bench for the link mode, filter and framer block
`timescale 1ns/100ps

module tb_top;
	import vpw_link_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic cpuWaitExec = 1'b0, cpuStopExec = 1'b0, waitToStopSelect = 1'b0;
	logic digitalLoopback = 1'b0, analogLoopback = 1'b0, encTxLevel = 1'b0;
	logic txInValid = 1'b0, txSymReady = 1'b0, other = 1'b0;
	txbyte_t txIn = '0;
	logic linkRxDigitalIn, linkTxDigitalOut, txInReady, txSymValid;
	logic rxFiltered, invalidSymbol, eofDetected, wakeIrq;
	logic clocksHalted, linkReady;
	sym_t txSym;
	mode_t modeState;
	sym_t exp[$];
	int nMismatch = 0, totalChecks = 0, cycles = 0;
	wire [3:0] ev = {eofDetected, invalidSymbol, wakeIrq, linkReady};

	// ----
	// Clock, design and bus partner
	// ----
	always #12.5 clk_sys = ~clk_sys;
	// Short end-of-frame and idle counts keep the run brief
	vpw_link_modes_rx_filter #(.EOF_CYCLES(40), .IDLE_CYCLES(60))
		vpw_link_modes_rx_filter_i (
		.clk_sys(clk_sys),
		.reset(reset),
		.cpuWaitExec(cpuWaitExec),
		.cpuStopExec(cpuStopExec),
		.waitToStopSelect(waitToStopSelect),
		.digitalLoopback(digitalLoopback),
		.analogLoopback(analogLoopback),
		.linkRxDigitalIn(linkRxDigitalIn),
		.linkTxDigitalOut(linkTxDigitalOut),
		.encTxLevel(encTxLevel),
		.txIn(txIn),
		.txInValid(txInValid),
		.txInReady(txInReady),
		.txSym(txSym),
		.txSymValid(txSymValid),
		.txSymReady(txSymReady),
		.rxFiltered(rxFiltered),
		.invalidSymbol(invalidSymbol),
		.eofDetected(eofDetected),
		.wakeIrq(wakeIrq),
		.clocksHalted(clocksHalted),
		.linkReady(linkReady),
		.modeState(modeState)
	);
	vpw_transceiver_model #(.ECHO_DLY(0)) vpw_transceiver_model_i (
		.clk_sys(clk_sys),
		.txLevel(linkTxDigitalOut),
		.otherActive(other),
		.busRx(linkRxDigitalIn)
	);

	// Cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			report_and_stop();
		end
	end

	// ----
	// Helpers
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		totalChecks++;
		if (seen !== want) begin
			nMismatch++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : check
	task automatic report_and_stop;
		if (nMismatch == 0 && totalChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic bus(input logic v);
		@(posedge clk_sys);
		other <= v;
	endtask : bus
	// Bounded wait for an event line: 0 ready, 1 wake, 2 bad symbol, 3 eof
	task automatic waitEv(input int k, input int n);
		for (int i = 0; i < n && ev[k] !== 1'b1; i++)
			cyc(1);
		check(ev[k], 1'b1);
	endtask : waitEv
	task automatic enterLow(input logic stopI, input logic sel);
		@(posedge clk_sys);
		cpuStopExec <= stopI;
		cpuWaitExec <= ~stopI;
		waitToStopSelect <= sel;
		@(posedge clk_sys);
		cpuStopExec <= 1'b0;
		cpuWaitExec <= 1'b0;
		cyc(1);
	endtask : enterLow
	task automatic push(input txbyte_t b);
		@(posedge clk_sys);
		txIn <= b;
		txInValid <= 1'b1;
		do @(posedge clk_sys); while (txInReady !== 1'b1);
		txInValid <= 1'b0;
	endtask : push
	// Expected symbols of one frame; CRC is MSB-first, complemented
	task automatic addFrame(input int a, input int b);
		logic [7:0] crc, d;
		crc = CRC_INIT;
		exp.push_back('{SYM_SOF, 1'b0});
		for (int i = a; i <= b; i++) begin
			d = 8'(i * 37 + 5);
			for (int j = 7; j >= 0; j--) begin
				exp.push_back('{SYM_BIT, d[j]});
				crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[j]) ? CRC_POLY : 8'h00);
			end
		end
		crc = ~crc;
		for (int j = 7; j >= 0; j--)
			exp.push_back('{SYM_BIT, crc[j]});
		exp.push_back('{SYM_EOD, 1'b0});
	endtask : addFrame
	// The encoder side stalls every other cycle
	task automatic collect(input int n);
		sym_t s;
		for (int i = 0; i < n;) begin
			@(posedge clk_sys);
			if (txSymValid === 1'b1 && txSymReady === 1'b1) begin
				s = txSym;
				if (s.kind != SYM_BIT)
					s.bitVal = 1'b0;
				check(s, exp.pop_front());
				i++;
			end
			txSymReady <= ~txSymReady;
		end
	endtask : collect

	// ----
	// Scenarios
	// ----
	task automatic tReset;
		@(posedge clk_sys);
		reset <= 1'b1;
		cyc(2);
		check(modeState, MODE_RESET);
		check(rxFiltered, 1'b0);
		check(txInReady, 1'b1);
		@(posedge clk_sys);
		reset <= 1'b0;
		cyc(2);
		check(modeState, MODE_RUN);
	endtask : tReset
	task automatic tFilter;
		bus(1'b1);
		cyc(17);
		check(rxFiltered, 1'b0);
		cyc(1);
		check(rxFiltered, 1'b1);
		bus(1'b0);
		cyc(10);
		bus(1'b1);
		cyc(30);
		check(rxFiltered, 1'b1);
		bus(1'b0);
		cyc(17);
		check(rxFiltered, 1'b1);
		cyc(1);
		check(rxFiltered, 1'b0);
		waitEv(2, 3);
	endtask : tFilter
	// Twelve bytes, end mark on the last only: eleven then a frame of one
	task automatic tFrame;
		for (int i = 0; i < 4; i++)
			push('{8'(i * 37 + 5), 1'b0});
		cyc(2);
		check(txInReady, 1'b0);
		addFrame(0, 10);
		addFrame(11, 11);
		fork
			for (int k = 4; k < 12; k++)
				push('{8'(k * 37 + 5), k == 11});
			collect(116);
		join
		cyc(4);
		check(txSymValid, 1'b0);
		check(txInReady, 1'b1);
	endtask : tFrame
	task automatic tWait;
		check(txSymValid, 1'b0);
		enterLow(1'b0, 1'b0);
		check(modeState, MODE_WAIT);
		bus(1'b1);
		waitEv(1, 20);
		check(modeState, MODE_RUN);
		bus(1'b0);
		cyc(20);
		enterLow(1'b0, 1'b0);
		waitEv(3, 60);
		waitEv(1, 2);
		check(modeState, MODE_RUN);
	endtask : tWait
	task automatic tStop;
		for (int k = 0; k < 2; k++) begin
			enterLow(k == 0, k == 1);
			check(clocksHalted, 1'b1);
			cyc(4);
			check(modeState, MODE_STOP);
			bus(1'b1);
			waitEv(1, 3);
			check(modeState, MODE_RUN);
			bus(1'b0);
			cyc(40);
		end
	endtask : tStop
	task automatic tLoop;
		@(posedge clk_sys);
		digitalLoopback <= 1'b1;
		encTxLevel <= 1'b1;
		cyc(19);
		check(linkTxDigitalOut, 1'b0);
		check(linkRxDigitalIn, 1'b0);
		check(rxFiltered, 1'b1);
		@(posedge clk_sys);
		digitalLoopback <= 1'b0;
		encTxLevel <= 1'b0;
		cyc(20);
		@(posedge clk_sys);
		analogLoopback <= 1'b1;
		encTxLevel <= 1'b1;
		cyc(2);
		check(linkTxDigitalOut, 1'b1);
		@(posedge clk_sys);
		analogLoopback <= 1'b0;
		encTxLevel <= 1'b0;
		bus(1'b1);
		cyc(40);
		check(linkReady, 1'b0);
		bus(1'b0);
		waitEv(0, 100);
	endtask : tLoop

	// Transmissions finish before any low-power entry
	initial begin
		tReset();
		tFilter();
		tFrame();
		tWait();
		tStop();
		tLoop();
		tReset();
		report_and_stop();
	end
endmodule : tb_top

// ---- bench/vpw_link_modes_rx_filter_assertions.sv ----
// Concurrent checks on the link mode, filter and loopback ports
`timescale 1ns/100ps

module vpw_link_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cpuWaitExec,
	input wire logic cpuStopExec,
	input wire logic waitToStopSelect,
	input wire logic digitalLoopback,
	input wire logic analogLoopback,
	input wire logic linkRxDigitalIn,
	input wire logic encTxLevel,
	input wire logic linkTxDigitalOut,
	input wire logic rxFiltered,
	input wire logic invalidSymbol,
	input wire logic eofDetected,
	input wire logic wakeIrq,
	input wire logic clocksHalted,
	input wire logic linkReady,
	input wire vpw_link_pkg::mode_t modeState
);
	import vpw_link_pkg::*;
	logic src;
	logic [4:0] hiRun_d, hiRun_q, loRun_d, loRun_q;

	// ----
	// Runs of one filter source level, saturating at 17
	// ----
	// Cleared while halted: the filter is frozen in stop
	always_comb begin
		src = digitalLoopback ? encTxLevel : linkRxDigitalIn;
		hiRun_d = 5'h0;
		loRun_d = 5'h0;
		if (src && !clocksHalted)
			hiRun_d = hiRun_q + {4'h0, hiRun_q != 5'h11};
		if (!src && !clocksHalted)
			loRun_d = loRun_q + {4'h0, loRun_q != 5'h11};
	end
	// Registers only
	always_ff @(posedge clk_sys) begin
		hiRun_q <= reset ? 5'h0 : hiRun_d;
		loRun_q <= reset ? 5'h0 : loRun_d;
	end

	default clocking cb @(posedge clk_sys); endclocking

	property p_reset_state;
		reset |=> modeState == MODE_RESET && !rxFiltered && !wakeIrq;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset mode not forced");
	property p_run_entry;
		disable iff (reset) $fell(reset) |=> modeState == MODE_RUN;
	endproperty
	a_run_entry: assert property (p_run_entry)
		else $error("run mode not entered");
	property p_to_wait;
		disable iff (reset) modeState == MODE_RUN && cpuWaitExec
			&& !waitToStopSelect && !cpuStopExec
			|=> modeState == MODE_WAIT && !clocksHalted;
	endproperty
	a_to_wait: assert property (p_to_wait)
		else $error("wait mode not entered");
	property p_to_stop;
		disable iff (reset) modeState == MODE_RUN && (cpuStopExec
			|| cpuWaitExec && waitToStopSelect)
			|=> modeState == MODE_STOP && clocksHalted;
	endproperty
	a_to_stop: assert property (p_to_stop)
		else $error("stop mode not entered");
	property p_wait_edge;
		disable iff (reset) modeState == MODE_WAIT && $rose(rxFiltered)
			|=> wakeIrq && modeState == MODE_RUN;
	endproperty
	a_wait_edge: assert property (p_wait_edge)
		else $error("no wake on bus edge");
	property p_wait_eof;
		disable iff (reset) modeState == MODE_WAIT && eofDetected |=> wakeIrq;
	endproperty
	a_wait_eof: assert property (p_wait_eof)
		else $error("no wake on end of frame");
	property p_stop_wake;
		disable iff (reset) modeState == MODE_STOP && src
			|=> wakeIrq && modeState == MODE_RUN;
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("no wake from stop");
	property p_filt_hi;
		disable iff (reset) hiRun_q == 5'h11 |-> rxFiltered;
	endproperty
	a_filt_hi: assert property (p_filt_hi)
		else $error("filtered output not set");
	property p_filt_lo;
		disable iff (reset) loRun_q == 5'h11 |-> !rxFiltered;
	endproperty
	a_filt_lo: assert property (p_filt_lo)
		else $error("filtered output not cleared");
	property p_dloop;
		disable iff (reset) digitalLoopback && $past(digitalLoopback)
			|-> !linkTxDigitalOut;
	endproperty
	a_dloop: assert property (p_dloop)
		else $error("transmit pin driven in loopback");
	property p_aloop;
		disable iff (reset) $fell(analogLoopback) && modeState == MODE_RUN
			|=> !linkReady [*8];
	endproperty
	a_aloop: assert property (p_aloop)
		else $error("no idle wait after analog loopback");

	c_wait_wake: cover property (modeState == MODE_WAIT ##1 wakeIrq);
	c_stop_wake: cover property (clocksHalted ##1 wakeIrq);
	c_bad_sym: cover property (invalidSymbol);
endmodule : vpw_link_checker

bind vpw_link_modes_rx_filter vpw_link_checker vpw_link_checker_i (
	.clk_sys(clk_sys),
	.reset(reset),
	.cpuWaitExec(cpuWaitExec),
	.cpuStopExec(cpuStopExec),
	.waitToStopSelect(waitToStopSelect),
	.digitalLoopback(digitalLoopback),
	.analogLoopback(analogLoopback),
	.linkRxDigitalIn(linkRxDigitalIn),
	.encTxLevel(encTxLevel),
	.linkTxDigitalOut(linkTxDigitalOut),
	.rxFiltered(rxFiltered),
	.invalidSymbol(invalidSymbol),
	.eofDetected(eofDetected),
	.wakeIrq(wakeIrq),
	.clocksHalted(clocksHalted),
	.linkReady(linkReady),
	.modeState(modeState)
);

// ---- bench/vpw_transceiver_model.sv ----
// Off-chip bus transceiver model: echo of our transmit plus other nodes
`timescale 1ns/100ps

module vpw_transceiver_model #(
	parameter int ECHO_DLY = 0
) (
	input wire logic clk_sys,
	input wire logic txLevel,
	input wire logic otherActive,
	output logic busRx
);
	logic [7:0] echo_q = 8'h00;

	// Echo lags by ECHO_DLY+1 cycles; active level wins on the wire
	always @(posedge clk_sys) begin
		echo_q <= {echo_q[6:0], txLevel};
	end
	assign busRx = otherActive | echo_q[ECHO_DLY];
endmodule : vpw_transceiver_model

// ---- design/vpw_link_modes_rx_filter.sv ----
// Link mode control, receive noise filter and transmit framer with FIFO
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Small synchronous FIFO
// ----------------------------------------------------------------
module vpw_tx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [AW:0] count_q, count_d;
	logic doWrite, doRead;

	// Full and empty come straight from the occupancy count
	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;

	// Pointer and count update
	always_comb begin
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (doWrite) begin
			wrPtr_d = (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
		end
		if (doRead) begin
			rdPtr_d = (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
		end
		if (doWrite && !doRead) begin
			count_d = count_q + 1'b1;
		end else if (doRead && !doWrite) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
		end
	end

	// Storage has no reset; contents are only read when counted valid
	always_ff @(posedge clk_sys) begin
		if (doWrite) begin
			mem[wrPtr_q] <= inData;
		end
	end
endmodule : vpw_tx_fifo

// Notes on behaviour
// - Any reset forces reset mode; state cleared, outputs held, input ignored.
// - Run mode is entered only after reset has been released.
// - Wait instruction with stop select clear enters wait mode, clocks run.
// - In wait, first passive-to-active edge raises wake interrupt, back to run.
// - In wait, a valid end-of-frame also raises the wake interrupt.
// - Stop instruction, or wait with stop select set, enters stop mode.
// - In stop, bus activity raises wake interrupt and returns to run.
// - Digital loopback ties transmit to receive internally, bus left passive.
// - Analog loopback changes nothing; on exit wait for idle bus.
// - Raw input is sampled each edge; sample steers the next count.
// - Counter counts up on high, down on low, saturating at 0 and 15.
// - Counter at fifteen sets the filtered output to one.
// - Counter at zero clears the filtered output to zero.
// - Output holds until opposite end; delay is 15 to 16 periods (16 to 17 here, counting one cycle behind the sample).
// - Filtered pulses shorter than shortest symbol flag invalid symbol.
// - At most 12 bytes per message, each sent most significant bit first.
// - Each message starts with a start-of-frame symbol excluded from CRC.
// - At least one data byte then the CRC byte, sent MSB to LSB.
module vpw_link_modes_rx_filter #(
	parameter int EOF_CYCLES = vpw_link_pkg::EOF_CYC,
	parameter int IDLE_CYCLES = vpw_link_pkg::IDLE_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cpuWaitExec,
	input wire logic cpuStopExec,
	input wire logic waitToStopSelect,
	input wire logic digitalLoopback,
	input wire logic analogLoopback,
	input wire logic linkRxDigitalIn,
	output logic linkTxDigitalOut,
	input wire logic encTxLevel,
	input wire vpw_link_pkg::txbyte_t txIn,
	input wire logic txInValid,
	output logic txInReady,
	output vpw_link_pkg::sym_t txSym,
	output logic txSymValid,
	input wire logic txSymReady,
	output logic rxFiltered,
	output logic invalidSymbol,
	output logic eofDetected,
	output logic wakeIrq,
	output logic clocksHalted,
	output logic linkReady,
	output vpw_link_pkg::mode_t modeState
);
	import vpw_link_pkg::*;

	// Serial CRC step, one bit at a time, MSB first
	function automatic logic [7:0] crcStep(input logic [7:0] c,
			input logic b);
		logic fb;
		fb = c[7] ^ b;
		crcStep = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
	endfunction : crcStep

	// ------------------------------------------------------------
	// Receive filter
	// ------------------------------------------------------------
	logic sample_q, sample_d;
	logic [3:0] filt_q, filt_d;
	logic out_q, out_d;
	logic rxSource;

	// Digital loopback takes our own transmit level instead of the pin
	assign rxSource = digitalLoopback ? encTxLevel : linkRxDigitalIn;

	// Counting is one cycle behind the sample, standing in for the
	// half-cycle offset; frozen while the internal clocks are halted
	always_comb begin
		sample_d = rxSource;
		filt_d = filt_q;
		out_d = out_q;
		if (modeState != MODE_STOP) begin
			if (sample_q && filt_q != FILT_TOP) begin
				filt_d = filt_q + 4'h1;
			end else if (!sample_q && filt_q != FILT_BOTTOM) begin
				filt_d = filt_q - 4'h1;
			end
			if (filt_q == FILT_TOP) begin
				out_d = 1'b1;
			end else if (filt_q == FILT_BOTTOM) begin
				out_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sample_q <= 1'b0;
			filt_q <= FILT_RESET;
			out_q <= FILT_OUT_RESET;
		end else begin
			sample_q <= sample_d;
			filt_q <= filt_d;
			out_q <= out_d;
		end
	end

	assign rxFiltered = out_q;

	// ------------------------------------------------------------
	// Run length, invalid symbol, end of frame and idle tracking
	// ------------------------------------------------------------
	logic [RUN_W-1:0] run_q, run_d;
	logic prevOut_q, prevOut_d;
	logic frame_q, frame_d;
	logic inval_q, inval_d;
	logic eof_q, eof_d;
	logic idleWait_q, idleWait_d;
	logic [RUN_W-1:0] idleCnt_q, idleCnt_d;
	logic aloopPrev_q, aloopPrev_d;
	logic edgeSeen, riseSeen;

	assign edgeSeen = out_q != prevOut_q;
	assign riseSeen = out_q && !prevOut_q;

	// One counter serves invalid symbol and end of frame: it measures the level since the last edge
	always_comb begin
		prevOut_d = out_q;
		aloopPrev_d = analogLoopback;
		run_d = run_q;
		frame_d = frame_q;
		inval_d = 1'b0;
		eof_d = 1'b0;
		idleWait_d = idleWait_q;
		idleCnt_d = '0;
		if (edgeSeen) begin
			run_d = '0;
			if (run_q < RUN_W'(MIN_SYMBOL_CYC)) begin
				inval_d = 1'b1;
			end
		end else if (run_q != RUN_W'(IDLE_CYCLES)) begin
			run_d = run_q + 1'b1;
		end
		if (out_q) begin
			frame_d = 1'b1;
		end else if (frame_q && run_q == RUN_W'(EOF_CYCLES - 1)) begin
			frame_d = 1'b0;
			eof_d = 1'b1;
		end
		// Leaving analog loopback blocks the link until a fresh idle
		// period has passed; time spent looped back does not count
		if (aloopPrev_q && !analogLoopback) begin
			idleWait_d = 1'b1;
		end else if (idleWait_q && idleCnt_q == RUN_W'(IDLE_CYCLES)) begin
			idleWait_d = 1'b0;
		end else if (idleWait_q && !out_q) begin
			idleCnt_d = idleCnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			run_q <= '0;
			prevOut_q <= FILT_OUT_RESET;
			frame_q <= 1'b0;
			inval_q <= 1'b0;
			eof_q <= 1'b0;
			idleWait_q <= 1'b0;
			idleCnt_q <= '0;
			aloopPrev_q <= 1'b0;
		end else begin
			run_q <= run_d;
			prevOut_q <= prevOut_d;
			frame_q <= frame_d;
			inval_q <= inval_d;
			eof_q <= eof_d;
			idleWait_q <= idleWait_d;
			idleCnt_q <= idleCnt_d;
			aloopPrev_q <= aloopPrev_d;
		end
	end

	assign invalidSymbol = inval_q;
	assign eofDetected = eof_q;

	// ------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------
	mode_t mode_q, mode_d;
	logic irq_q, irq_d;
	logic txOut_q, txOut_d;

	// Wake sources: a filtered rising edge or end of frame in wait;
	// raw receive source in stop (pin, or own transmit in digital loopback) since the filter is frozen there
	always_comb begin
		mode_d = mode_q;
		irq_d = 1'b0;
		unique case (mode_q)
			MODE_RESET: mode_d = MODE_RUN;
			MODE_RUN: begin
				if (cpuStopExec || (cpuWaitExec && waitToStopSelect)) begin
					mode_d = MODE_STOP;
				end else if (cpuWaitExec) begin
					mode_d = MODE_WAIT;
				end
			end
			MODE_WAIT: begin
				if (riseSeen || eof_q) begin
					irq_d = 1'b1;
					mode_d = MODE_RUN;
				end
			end
			MODE_STOP: begin
				if (rxSource) begin
					irq_d = 1'b1;
					mode_d = MODE_RUN;
				end
			end
		endcase
		// Digital loopback keeps the pin passive
		txOut_d = digitalLoopback ? 1'b0 : encTxLevel;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mode_q <= MODE_RESET;
			irq_q <= 1'b0;
			txOut_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			irq_q <= irq_d;
			txOut_q <= txOut_d;
		end
	end

	assign modeState = mode_q;
	assign wakeIrq = irq_q;
	assign clocksHalted = (mode_q == MODE_STOP);
	assign linkTxDigitalOut = txOut_q;
	// A new frame only starts in run mode outside the idle wait; the host drains it first
	assign linkReady = (mode_q == MODE_RUN) && !idleWait_q;

	// ------------------------------------------------------------
	// Transmit byte FIFO
	// ------------------------------------------------------------
	txbyte_t fifoOut;
	logic fifoValid, fifoPop;

	vpw_tx_fifo #(
		.WIDTH(TXBYTE_W),
		.DEPTH(TX_FIFO_DEPTH)
	) vpw_tx_fifo_i (
		.clk_sys(clk_sys),
		.reset(reset),
		.inData(txIn),
		.inValid(txInValid),
		.inReady(txInReady),
		.outData(fifoOut),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	// ------------------------------------------------------------
	// Transmit framer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE, TX_DATA, TX_SHIFT, TX_CRC, TX_EOD
	} txstate_t;
	txstate_t tx_q, tx_d;
	logic [7:0] byte_q, byte_d, crc_q, crc_d, crcNext;
	logic [2:0] bit_q, bit_d;
	logic [3:0] cnt_q, cnt_d;
	logic last_q, last_d;
	sym_t sym_q, sym_d;
	logic symV_q, symV_d;
	logic slotFree;

	// A symbol slot is free when nothing is held or it is being taken
	assign slotFree = !symV_q || txSymReady;
	assign crcNext = crcStep(crc_q, byte_q[bit_q]);

	always_comb begin
		tx_d = tx_q;
		byte_d = byte_q;
		crc_d = crc_q;
		bit_d = bit_q;
		cnt_d = cnt_q;
		last_d = last_q;
		sym_d = sym_q;
		symV_d = symV_q && !txSymReady;
		fifoPop = 1'b0;
		if (slotFree) begin
			unique case (tx_q)
				TX_IDLE: begin
					if (fifoValid && linkReady) begin
						sym_d = '{kind: SYM_SOF, bitVal: 1'b0};
						symV_d = 1'b1;
						crc_d = CRC_INIT;
						cnt_d = 4'h0;
						tx_d = TX_DATA;
					end
				end
				TX_DATA: begin
					// An empty FIFO mid-frame stalls the framer
					if (fifoValid) begin
						fifoPop = 1'b1;
						byte_d = fifoOut.data;
						// Byte count includes the CRC byte
						last_d = fifoOut.last ||
							(cnt_q == MAX_MSG_BYTES - 4'h2);
						bit_d = BYTE_MSB;
						tx_d = TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					sym_d = '{kind: SYM_BIT, bitVal: byte_q[bit_q]};
					symV_d = 1'b1;
					crc_d = crcNext;
					bit_d = bit_q - 3'h1;
					if (bit_q == 3'h0) begin
						cnt_d = cnt_q + 4'h1;
						if (last_q) begin
							byte_d = ~crcNext;
							bit_d = BYTE_MSB;
							tx_d = TX_CRC;
						end else begin
							tx_d = TX_DATA;
						end
					end
				end
				TX_CRC: begin
					sym_d = '{kind: SYM_BIT, bitVal: byte_q[bit_q]};
					symV_d = 1'b1;
					bit_d = bit_q - 3'h1;
					if (bit_q == 3'h0) begin
						tx_d = TX_EOD;
					end
				end
				TX_EOD: begin
					sym_d = '{kind: SYM_EOD, bitVal: 1'b0};
					symV_d = 1'b1;
					tx_d = TX_IDLE;
				end
				default: tx_d = TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_q <= TX_IDLE;
			byte_q <= 8'h00;
			crc_q <= CRC_INIT;
			bit_q <= BYTE_MSB;
			cnt_q <= 4'h0;
			last_q <= 1'b0;
			sym_q <= '{kind: SYM_SOF, bitVal: 1'b0};
			symV_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			byte_q <= byte_d;
			crc_q <= crc_d;
			bit_q <= bit_d;
			cnt_q <= cnt_d;
			last_q <= last_d;
			sym_q <= sym_d;
			symV_q <= symV_d;
		end
	end

	assign txSym = sym_q;
	assign txSymValid = symV_q;
endmodule : vpw_link_modes_rx_filter

// ---- design/vpw_link_pkg.sv ----
// Shared constants and types for the link mode, filter and framing logic
package vpw_link_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int MIN_SYMBOL_US = 64;
	localparam int EOF_US = 280;
	localparam int IDLE_US = 300;
	// Cycle counts derived from the times above
	localparam int MIN_SYMBOL_CYC = MIN_SYMBOL_US * CLK_MHZ;
	localparam int EOF_CYC = EOF_US * CLK_MHZ;
	localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
	localparam int RUN_W = 14;

	// ------------------------------------------------------------
	// Receive filter
	// ------------------------------------------------------------
	localparam logic [3:0] FILT_TOP = 4'hf;
	localparam logic [3:0] FILT_BOTTOM = 4'h0;
	localparam logic [3:0] FILT_RESET = 4'h0;
	localparam logic FILT_OUT_RESET = 1'b0;

	// ------------------------------------------------------------
	// Frame format
	// ------------------------------------------------------------
	localparam logic [3:0] MAX_MSG_BYTES = 4'hc;
	localparam logic [2:0] BYTE_MSB = 3'h7;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h1d;
	localparam int TX_FIFO_DEPTH = 4;
	localparam int TXBYTE_W = 9;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RESET, MODE_RUN, MODE_WAIT, MODE_STOP
	} mode_t;

	typedef enum logic [1:0] {SYM_SOF, SYM_BIT, SYM_EOD} symkind_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} txbyte_t;

	typedef struct packed {
		symkind_t kind;
		logic bitVal;
	} sym_t;

endpackage : vpw_link_pkg
